//--- cpf_pkg.sv
// Constants for the feature-control and flags register block
// Function
// - Global translations survive page-table base writes
// - Global marker honoured only at leaf level
// - Counter read any level if bit 8
// - Bit 9 enables legacy SIMD instructions
// - Bit 9 clear: legacy SIMD raises invalid-opcode
// - State save/restore always works for base state
// - Bit 10 clear: SIMD FP error becomes invalid-opcode
// - Bit 16 enables segment-base instructions in 64-bit
// - Bit 18 enables extended-control read/write
// - Extended save covers base plus enabled components
// - Bit 20 blocks supervisor fetch from user pages
// - Control registers 1,5-7,9-15 raise invalid-opcode
// - Extension bit widens register number in 64-bit
// - Unimplemented control register raises invalid-opcode
// - Register 8 is task priority, 64-bit only
// - Hardware writes status flags, anyone reads
// - Legacy flags view equals low 32 bits
// - Legacy mode sees low 32 feature bits
// - Defined feature bits read and write
package cpf_pkg;
  // Feature-control bit positions
  localparam int FC_GPE = 7;
  localparam int FC_CRE = 8;
  localparam int FC_SRS = 9;
  localparam int FC_UXS = 10;
  localparam int FC_SBE = 16;
  localparam int FC_XSE = 18;
  localparam int FC_SEP = 20;
  // Defined feature bits
  localparam logic [63:0] FC_DEFINED = 64'h0000_0000_0035_07ff;
  localparam logic [63:0] FC_RESET = 64'h0;
  // Control register numbers
  localparam logic [3:0] CRN_FEAT = 4'h4;
  localparam logic [3:0] CRN_TPR = 4'h8;
  localparam int TPR_W = 4;
  // Flags layout
  localparam logic [63:0] FLG_STATUS = 64'h0000_0000_0000_08d5;
  localparam logic [63:0] FLG_WRITABLE = 64'h0000_0000_003f_7fd5;
  localparam logic [63:0] FLG_RESET = 64'h0000_0000_0000_0002;
  localparam int FLG_CF = 0;
  localparam int FLG_PF = 2;
  localparam int FLG_AF = 4;
  localparam int FLG_ZF = 6;
  localparam int FLG_SF = 7;
  localparam int FLG_OF = 11;
  // Base state component of the extended save mask
  localparam logic [63:0] XS_BASE = 64'h1;
  // Instruction classes presented for checking
  typedef enum logic [2:0] {
    IC_CTR_READ = 3'h0,
    IC_LEG_SIMD = 3'h1,
    IC_STATE_SR = 3'h2,
    IC_SEG_BASE = 3'h3,
    IC_EXT_CTRL = 3'h4,
    IC_EXT_SR = 3'h5
  } cpf_iclass_t;
endpackage

//--- cpf_ctrl_regs.sv
// Feature-control, task-priority and flags register logic
`timescale 1ns/1ps
`default_nettype none
module cpf_ctrl_regs #(
  parameter bit SEP_SUPPORTED = 1'b1,
  parameter bit SBE_SUPPORTED = 1'b1,
  parameter bit HIGH_CR_IMPL = 1'b0
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Execution mode
  input wire logic MODE64,
  input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL,
  // Control register access
  input wire logic CR_REQ,
  input wire logic CR_WR,
  input wire logic [2:0] CR_REG,
  input wire logic REGISTER_EXTENSION_BIT,
  input wire logic [63:0] CR_WDATA,
  output logic CR_DONE,
  output logic CR_UD,
  output logic CR_GP,
  output logic CR_OTHER,
  output logic [63:0] CR_RDATA,
  // Instruction permission check
  input wire logic CHK_REQ,
  input wire cpf_pkg::cpf_iclass_t CHK_CLASS,
  output logic CHK_DONE,
  output logic CHK_UD,
  output logic CHK_GP,
  // SIMD floating-point error routing
  input wire logic SFP_ERR,
  output logic SFP_XF,
  output logic SFP_UD,
  // Extended save mask
  input wire logic [63:0] XFC_VAL,
  output logic [63:0] XS_MASK,
  // Translation buffer control
  input wire logic PTB_WR,
  output logic TLB_FLUSH,
  output logic TLB_KEEP_GLOBAL,
  input wire logic WALK_VALID,
  input wire logic WALK_LEAF,
  input wire logic WALK_G,
  output logic WALK_GLOBAL,
  // Fetch protection
  input wire logic FETCH_VALID,
  input wire logic FETCH_USER_PAGE,
  output logic FETCH_FAULT,
  // Flags
  input wire logic ALU_WE,
  input wire logic [5:0] ALU_FLAGS,
  input wire logic FLG_WE,
  input wire logic [63:0] FLG_WDATA,
  output logic [63:0] FLAGS,
  output logic [31:0] LEGACY_FLAGS,
  // Feature bits and task priority for the core
  output logic [63:0] FEATURES,
  output logic [cpf_pkg::TPR_W-1:0] TASK_PRIORITY
);
  import cpf_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [63:0] feature_control; // Feature enables
  logic [TPR_W-1:0] task_priority; // Task priority
  logic [63:0] flags_word; // Flags

  // ****************************************
  // Access decode
  // ****************************************
  // Full register number, extension bit only in 64-bit
  wire [3:0] cr_num = {REGISTER_EXTENSION_BIT & MODE64, CR_REG};
  // Defined bits, minus unsupported features
  wire [63:0] fc_mask = FC_DEFINED
    & ~(SEP_SUPPORTED ? 64'h0 : (64'h1 << FC_SEP))
    & ~(SBE_SUPPORTED ? 64'h0 : (64'h1 << FC_SBE));
  wire is_feat = (cr_num == CRN_FEAT);
  wire is_tpr = (cr_num == CRN_TPR) && MODE64;
  // Registers held elsewhere in the core
  wire is_other = (cr_num == 4'h0) || (cr_num == 4'h2) || (cr_num == 4'h3);
  // Reserved and unimplemented numbers
  wire cr_bad = !(is_feat || is_tpr || is_other)
    && !(HIGH_CR_IMPL && cr_num > 4'h8);
  wire priv_bad = (CURRENT_PRIVILEGE_LEVEL != 2'h0);
  // Reserved bits set on write fault
  wire feat_rsv = is_feat && |(CR_WDATA & ~fc_mask);
  wire tpr_rsv = is_tpr && |CR_WDATA[63:TPR_W];
  wire wr_fault = CR_WR && (feat_rsv || tpr_rsv);
  wire acc_ok = CR_REQ && !cr_bad && !priv_bad && !is_other;
  wire feat_we = acc_ok && CR_WR && is_feat && !wr_fault;
  wire tpr_we = acc_ok && CR_WR && is_tpr && !wr_fault;
  // Legacy mode sees only the low half
  wire [63:0] feat_view = MODE64 ? feature_control
    : {32'h0, feature_control[31:0]};
  wire [63:0] next_rdata = is_tpr ? {{(64-TPR_W){1'b0}}, task_priority}
    : feat_view;

  // ****************************************
  // Instruction checks
  // ****************************************
  wire gpe = feature_control[FC_GPE];
  wire cre = feature_control[FC_CRE];
  wire srs = feature_control[FC_SRS];
  wire uxs = feature_control[FC_UXS];
  wire sbe = feature_control[FC_SBE];
  wire xse = feature_control[FC_XSE];
  wire sep = feature_control[FC_SEP];
  logic ck_ud; // Check gives invalid opcode
  logic ck_gp; // Check gives protection fault
  // Per-class permission
  always_comb begin
    ck_ud = 1'b0;
    ck_gp = 1'b0;
    case (CHK_CLASS)
      IC_CTR_READ: ck_gp = !cre && priv_bad;
      IC_LEG_SIMD: ck_ud = !srs;
      IC_STATE_SR: ck_ud = 1'b0;
      IC_SEG_BASE: ck_ud = !(sbe && MODE64);
      IC_EXT_CTRL: ck_ud = !xse;
      IC_EXT_SR: ck_ud = !xse;
      default: ck_ud = 1'b1;
    endcase
  end

  // ****************************************
  // Flags next value
  // ****************************************
  wire [63:0] alu_bits = ({63'h0, ALU_FLAGS[0]} << FLG_CF)
    | ({63'h0, ALU_FLAGS[1]} << FLG_PF) | ({63'h0, ALU_FLAGS[2]} << FLG_AF)
    | ({63'h0, ALU_FLAGS[3]} << FLG_ZF) | ({63'h0, ALU_FLAGS[4]} << FLG_SF)
    | ({63'h0, ALU_FLAGS[5]} << FLG_OF);
  wire [63:0] sw_flags = FLG_WE ? ((flags_word & ~FLG_WRITABLE)
    | (FLG_WDATA & FLG_WRITABLE)) : flags_word;
  // Arithmetic result wins over a same-cycle software write
  wire [63:0] next_flags = (ALU_WE ? ((sw_flags & ~FLG_STATUS)
    | alu_bits) : sw_flags) | FLG_RESET;

  // ****************************************
  // Registers
  // ****************************************
  // Feature and priority state
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      feature_control <= FC_RESET;
      task_priority <= '0;
    end else begin
      if (feat_we) begin
        feature_control <= CR_WDATA & fc_mask;
      end
      if (tpr_we) begin
        task_priority <= CR_WDATA[TPR_W-1:0];
      end
    end
  end

  // Flags state
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flags_word <= FLG_RESET;
    end else begin
      flags_word <= next_flags;
    end
  end

  // Access answer
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CR_DONE <= 1'b0;
      CR_UD <= 1'b0;
      CR_GP <= 1'b0;
      CR_OTHER <= 1'b0;
      CR_RDATA <= 64'h0;
    end else begin
      CR_DONE <= CR_REQ;
      CR_UD <= CR_REQ && cr_bad;
      CR_GP <= CR_REQ && !cr_bad && !is_other && (priv_bad || wr_fault);
      CR_OTHER <= CR_REQ && is_other;
      CR_RDATA <= (acc_ok && !CR_WR) ? next_rdata : 64'h0;
    end
  end

  // Check answer and event routing
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      CHK_DONE <= 1'b0;
      CHK_UD <= 1'b0;
      CHK_GP <= 1'b0;
      SFP_XF <= 1'b0;
      SFP_UD <= 1'b0;
      TLB_FLUSH <= 1'b0;
      TLB_KEEP_GLOBAL <= 1'b0;
      WALK_GLOBAL <= 1'b0;
      FETCH_FAULT <= 1'b0;
    end else begin
      CHK_DONE <= CHK_REQ;
      CHK_UD <= CHK_REQ && ck_ud;
      CHK_GP <= CHK_REQ && ck_gp;
      SFP_XF <= SFP_ERR && uxs;
      SFP_UD <= SFP_ERR && !uxs;
      TLB_FLUSH <= PTB_WR;
      TLB_KEEP_GLOBAL <= PTB_WR && gpe;
      WALK_GLOBAL <= WALK_VALID && gpe && WALK_LEAF && WALK_G;
      FETCH_FAULT <= FETCH_VALID && sep && !priv_bad
        && FETCH_USER_PAGE;
    end
  end

  // Flag, feature, task-priority and save-mask views
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FLAGS <= FLG_RESET;
      LEGACY_FLAGS <= FLG_RESET[31:0];
      FEATURES <= FC_RESET;
      TASK_PRIORITY <= '0;
      XS_MASK <= 64'h0;
    end else begin
      FLAGS <= next_flags;
      LEGACY_FLAGS <= next_flags[31:0];
      FEATURES <= feat_we ? (CR_WDATA & fc_mask) : feature_control;
      TASK_PRIORITY <= tpr_we ? CR_WDATA[TPR_W-1:0] : task_priority;
      XS_MASK <= xse ? (XFC_VAL | XS_BASE) : 64'h0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  keep_global_a: assert property (PTB_WR |=> TLB_FLUSH
    && (TLB_KEEP_GLOBAL == $past(gpe)))
    else $error("global keep wrong");
  leaf_global_a: assert property (WALK_VALID && !WALK_LEAF |=> !WALK_GLOBAL)
    else $error("non-leaf global honoured");
  ctr_priv_a: assert property (CHK_REQ && CHK_CLASS == IC_CTR_READ
    && CURRENT_PRIVILEGE_LEVEL == 2'h0 |=> CHK_DONE && !CHK_GP)
    else $error("counter read refused at level 0");
  simd_off_a: assert property (CHK_REQ && CHK_CLASS == IC_LEG_SIMD
    |=> CHK_UD == !$past(srs))
    else $error("legacy SIMD gate wrong");
  state_sr_a: assert property (CHK_REQ && CHK_CLASS == IC_STATE_SR
    |=> !CHK_UD && !CHK_GP)
    else $error("state save refused");
  sfp_route_a: assert property (SFP_ERR && !uxs |=> SFP_UD && !SFP_XF)
    else $error("SIMD error not converted");
  seg_mode_a: assert property (CHK_REQ && CHK_CLASS == IC_SEG_BASE
    && !MODE64 |=> CHK_UD)
    else $error("segment base outside 64-bit");
  ext_ctrl_a: assert property (CHK_REQ && CHK_CLASS == IC_EXT_CTRL
    |=> CHK_UD == !$past(xse))
    else $error("extended control gate wrong");
  fetch_prot_a: assert property (FETCH_VALID && FETCH_USER_PAGE && CURRENT_PRIVILEGE_LEVEL == 2'h0
    && sep |=> FETCH_FAULT)
    else $error("supervisor user fetch allowed");
  bad_cr_a: assert property (CR_REQ && (cr_num == 4'h1 || cr_num == 4'h5)
    |=> CR_UD ##1 !CR_UD)
    else $error("reserved register not refused");
  legacy_view_a: assert property (LEGACY_FLAGS == FLAGS[31:0])
    else $error("legacy flags differ");
  rsv_zero_a: assert property (CR_REQ && CR_WR && feat_rsv
    |=> CR_GP && $stable(feature_control))
    else $error("reserved bits stored");
  feat_rw_a: assert property (feat_we |=> feature_control == $past(CR_WDATA)
    ##1 FEATURES == $past(feature_control, 1))
    else $error("feature write lost");

  cov_feat_wr_c: cover property (feat_we ##1 CR_REQ && !CR_WR && is_feat);
  cov_tpr_c: cover property (tpr_we);
  cov_fetch_c: cover property (FETCH_FAULT);
  cov_keep_c: cover property (TLB_KEEP_GLOBAL);
endmodule
`default_nettype wire

//--- tb_cpu_control_register_features.sv
// Self-checking bench for the feature-control, task-priority and flags block
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_control_register_features;
  import cpf_pkg::*;
  // ****************
  // Stimulus and observed signals
  // ****************
  logic clk_sys = 1'b0, rst = 1'b1, mode64 = 1'b1, cr_req = 1'b0, cr_wr = 1'b0, register_extension_bit = 1'b0, chk_req = 1'b0;
  logic sfp_err = 1'b0, ptb_wr = 1'b0, walk_valid = 1'b0, walk_leaf = 1'b1, walk_g = 1'b1, fetch_valid = 1'b0;
  logic fetch_user_page = 1'b1, alu_we = 1'b0, flg_we = 1'b0;
  logic [1:0] current_privilege_level = 2'h0;
  logic [2:0] cr_reg = 3'h0;
  logic [5:0] alu_flags = 6'h0;
  logic [63:0] cr_wdata = 64'h0, xfc_val = 64'h6, flg_wdata = 64'h0;
  cpf_iclass_t chk_class = IC_CTR_READ;
  // Outputs of the block
  logic cr_done, cr_ud, cr_gp, cr_other, chk_done, chk_ud, chk_gp, sfp_xf, sfp_ud;
  logic tlb_flush, tlb_keep_global, walk_global, fetch_fault;
  logic [63:0] cr_rdata, xs_mask, flags, features, rd;
  logic [31:0] legacy_flags;
  logic [TPR_W-1:0] task_priority;
  int error_cnt = 0, checks_done = 0;

  cpf_ctrl_regs dut (.CLK_SYS(clk_sys), .RST(rst), .MODE64(mode64), .CURRENT_PRIVILEGE_LEVEL(current_privilege_level), .CR_REQ(cr_req), .CR_WR(cr_wr),
    .CR_REG(cr_reg), .REGISTER_EXTENSION_BIT(register_extension_bit), .CR_WDATA(cr_wdata), .CR_DONE(cr_done), .CR_UD(cr_ud), .CR_GP(cr_gp),
    .CR_OTHER(cr_other), .CR_RDATA(cr_rdata), .CHK_REQ(chk_req), .CHK_CLASS(chk_class), .CHK_DONE(chk_done),
    .CHK_UD(chk_ud), .CHK_GP(chk_gp), .SFP_ERR(sfp_err), .SFP_XF(sfp_xf), .SFP_UD(sfp_ud), .XFC_VAL(xfc_val),
    .XS_MASK(xs_mask), .PTB_WR(ptb_wr), .TLB_FLUSH(tlb_flush), .TLB_KEEP_GLOBAL(tlb_keep_global),
    .WALK_VALID(walk_valid), .WALK_LEAF(walk_leaf), .WALK_G(walk_g), .WALK_GLOBAL(walk_global),
    .FETCH_VALID(fetch_valid), .FETCH_USER_PAGE(fetch_user_page), .FETCH_FAULT(fetch_fault), .ALU_WE(alu_we),
    .ALU_FLAGS(alu_flags), .FLG_WE(flg_we), .FLG_WDATA(flg_wdata), .FLAGS(flags), .LEGACY_FLAGS(legacy_flags),
    .FEATURES(features), .TASK_PRIORITY(task_priority));

  // ****************
  // Shared tasks
  // ****************
  // Compare and count
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One register access, answer judged one cycle later; exp is {ud, other, gp}
  task automatic cr(input logic wr, input logic [3:0] num, input logic [63:0] d, input logic [2:0] exp);
    // Idle cycle first, so the request line never drops and rises in one step
    @(negedge clk_sys);
    cr_req = 1'b1;
    cr_wr = wr;
    register_extension_bit = num[3];
    cr_reg = num[2:0];
    cr_wdata = d;
    @(negedge clk_sys);
    cr_req = 1'b0;
    rd = cr_rdata;
    check("cr answer", {cr_done, cr_ud, cr_other, cr_gp}, {1'b1, exp});
  endtask
  // One permission check; exp is {ud, gp}
  task automatic chk(input cpf_iclass_t c, input logic [1:0] exp);
    @(negedge clk_sys);
    chk_req = 1'b1;
    chk_class = c;
    @(negedge clk_sys);
    chk_req = 1'b0;
    check("check answer", {chk_done, chk_ud, chk_gp}, {1'b1, exp});
  endtask
  // All four event inputs pulsed together; exp is {xf, ud, flush, keep, global, fault}
  task automatic ev(input logic [5:0] exp);
    @(negedge clk_sys);
    {sfp_err, ptb_wr, walk_valid, fetch_valid} = 4'hf;
    @(negedge clk_sys);
    {sfp_err, ptb_wr, walk_valid, fetch_valid} = 4'h0;
    check("events", {sfp_xf, sfp_ud, tlb_flush, tlb_keep_global, walk_global, fetch_fault}, {58'h0, exp});
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  // Feature register access, reserved bits, privilege, legacy view, task priority
  task automatic t_feat();
    cr(1'b1, 4'h4, 64'h80, 3'h0);
    check("features", features, 64'h80);
    cr(1'b0, 4'h4, 64'h0, 3'h0);
    check("feature read", rd, 64'h80);
    cr(1'b1, 4'h4, 64'h2_0080, 3'h1);
    check("features kept", features, 64'h80);
    current_privilege_level = 2'h3;
    cr(1'b1, 4'h4, 64'h0, 3'h1);
    current_privilege_level = 2'h0;
    cr(1'b1, 4'h4, FC_DEFINED, 3'h0);
    mode64 = 1'b0;
    cr(1'b0, 4'h4, 64'h0, 3'h0);
    check("legacy feature read", rd, FC_DEFINED & 64'hffff_ffff);
    mode64 = 1'b1;
    cr(1'b1, 4'h8, 64'h5, 3'h0);
    check("task priority", {60'h0, task_priority}, 64'h5);
    cr(1'b1, 4'h8, 64'h10, 3'h1);
    cr(1'b0, 4'h8, 64'h0, 3'h0);
    check("priority read", rd, 64'h5);
    cr(1'b1, 4'h4, 64'h0, 3'h0);
    $display("test feature access done");
  endtask
  // Every register number through the extension bit
  task automatic t_crnum();
    logic ud;
    logic oth;
    for (int n = 0; n < 16; n++) begin
      ud = (n inside {1, 5, 6, 7}) || n > 8;
      oth = n inside {0, 2, 3};
      cr(1'b0, n[3:0], 64'h0, {ud, oth, 1'b0});
    end
    $display("test register numbers done");
  endtask
  // Instruction permission by feature bits, mode and privilege
  task automatic t_check();
    logic [11:0] exp_off;
    exp_off = 12'ha89;
    current_privilege_level = 2'h3;
    for (int i = 0; i < 6; i++) begin
      chk(cpf_iclass_t'(i), exp_off[2*i+:2]);
    end
    current_privilege_level = 2'h0;
    chk(IC_CTR_READ, 2'h0);
    check("save mask off", xs_mask, 64'h0);
    cr(1'b1, 4'h4, 64'h200, 3'h0); // SIMD enabled before extended state
    cr(1'b1, 4'h4, 64'h5_0300, 3'h0);
    current_privilege_level = 2'h3;
    for (int i = 0; i < 6; i++) begin
      chk(cpf_iclass_t'(i), 2'h0);
    end
    check("save mask on", xs_mask, 64'h7);
    mode64 = 1'b0;
    chk(IC_SEG_BASE, 2'h2);
    mode64 = 1'b1;
    current_privilege_level = 2'h0;
    $display("test permission checks done");
  endtask
  // Error routing, global pages and fetch protection
  task automatic t_events();
    ev(6'h18);
    cr(1'b1, 4'h4, 64'h10_0480, 3'h0);
    ev(6'h2f);
    walk_leaf = 1'b0;
    current_privilege_level = 2'h3;
    ev(6'h2c);
    walk_leaf = 1'b1;
    current_privilege_level = 2'h0;
    $display("test events done");
  endtask
  // Status flags from the ALU and from software, legacy view
  task automatic t_flags();
    check("flags at reset", flags, 64'h2);
    alu_we = 1'b1;
    alu_flags = 6'h3f;
    @(negedge clk_sys);
    alu_we = 1'b0;
    check("alu flags", flags, FLG_STATUS | 64'h2);
    flg_we = 1'b1;
    flg_wdata = 64'hffff_ffff_ffff_ffff;
    @(negedge clk_sys);
    check("sw flags", flags, FLG_WRITABLE | 64'h2);
    check("legacy flags", {32'h0, legacy_flags}, (FLG_WRITABLE | 64'h2) & 64'hffff_ffff);
    alu_we = 1'b1;
    alu_flags = 6'h0;
    @(negedge clk_sys);
    {alu_we, flg_we} = 2'h0;
    check("alu over sw", flags, (FLG_WRITABLE | 64'h2) & ~FLG_STATUS);
    $display("test flags done");
  endtask

  // ****************
  // Clock, watchdog and main sequence
  // ****************
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    check("reset state", {features[31:0], xs_mask[7:0], 4'h0, task_priority}, 64'h0);
    t_flags();
    t_feat();
    t_crnum();
    t_check();
    t_events();
    test_done();
  end
endmodule
`default_nettype wire
